// ### bwm_pkg.sv
// Purpose: shared constants and carriers for the burst write byte mask block
// Assumes: one 200 MHz clock, beats presented as one-cycle strobes
// Notes: organisation selected by lane count and lane width parameters
package bwm_pkg;
    // ------------------------------------------------------------
    // burst shape
    // ------------------------------------------------------------
    localparam int BWM_BEATS = 4;
    localparam int BWM_BEAT_W = 2;
    localparam int BWM_WORD_W = 36;
    localparam int BWM_LANES_MAX = 4;
    localparam int BWM_DEF_ADDR_W = 6;
    localparam logic [1:0] BWM_BEAT_FIRST = 2'h0;
    localparam logic [1:0] BWM_BEAT_LAST = 2'h3;
    localparam logic [3:0] BWM_MASK_NONE = 4'hf;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [BWM_WORD_W-1:0] data;
        logic [BWM_LANES_MAX-1:0] lane_mask_n;
    } bwm_beat_t;

    typedef enum logic [2:0] {
        BWM_IDLE = 3'b001,
        BWM_WAIT = 3'b010,
        BWM_DATA = 3'b100
    } bwm_state_t;
endpackage : bwm_pkg

// ### bwm_array.sv
// Purpose: burst word array with per bit write enable
// Assumes: single clock, registered read data
// Notes: lane masking reduces to a bit enable vector
module bwm_array #(
    parameter int ADDR_W = 6,
    parameter int DATA_W = 36
) (
    input wire logic sys_clk_in,
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic [DATA_W-1:0] wr_bit_en_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [DATA_W-1:0] rd_data_out
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            // unselected bits keep their old contents
            mem[wr_addr_in] <= (mem[wr_addr_in] & ~wr_bit_en_in) |
                (wr_data_in & wr_bit_en_in);
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule : bwm_array

// ### bwm_top.sv
// Purpose: per beat lane masked writes of a four beat burst
// Assumes: true/complement clock rises arrive as alternate sys clock
//          cycles; beat data and masks sampled each cycle of the burst
// Notes: lane width 4 with two lanes is the nibble organisation
module bwm_top #(
    parameter int LANES = 4,
    parameter int LANE_W = 9,
    parameter int ADDR_W = bwm_pkg::BWM_DEF_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic write_port_select_n_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire bwm_pkg::bwm_beat_t beat_in,
    input wire logic [ADDR_W+1:0] rd_addr_in,
    output logic [bwm_pkg::BWM_WORD_W-1:0] rd_data_out,
    output logic busy_out,
    output logic beat_strobe_out
);
    import bwm_pkg::*;
    localparam int DW = LANES * LANE_W;

    localparam bit ORG_OK = (LANES == 2 && LANE_W == 4) ||
        (LANES == 1 && LANE_W == 9) || (LANES == 2 && LANE_W == 9) ||
        (LANES == 4 && LANE_W == 9);

    // refuse builds that have no lane table behind them
    if (!ORG_OK || ADDR_W < 1) begin : g_bad_org
        $error("unsupported organisation");
    end

    // ------------------------------------------------------------
    // pin capture
    // ------------------------------------------------------------
    // two stages, pins come from outside the clock domain
    // address buses are held steady around their strobe, so per bit
    // capture still lands one coherent word
    logic start_n_s1, start_n_s2;
    bwm_beat_t beat_s1, beat_s2;
    logic [ADDR_W-1:0] waddr_s1, waddr_s2;
    logic [ADDR_W+1:0] raddr_s1, raddr_s2;
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            start_n_s1 <= 1'b1;
            start_n_s2 <= 1'b1;
            beat_s1 <= '0;
            beat_s2 <= '0;
            waddr_s1 <= '0;
            waddr_s2 <= '0;
            raddr_s1 <= '0;
            raddr_s2 <= '0;
        end else begin
            start_n_s1 <= write_port_select_n_in;
            start_n_s2 <= start_n_s1;
            beat_s1 <= beat_in;
            beat_s2 <= beat_s1;
            waddr_s1 <= wr_addr_in;
            waddr_s2 <= waddr_s1;
            raddr_s1 <= rd_addr_in;
            raddr_s2 <= raddr_s1;
        end
    end

    // ------------------------------------------------------------
    // lane mask expansion
    // ------------------------------------------------------------
    function automatic logic [DW-1:0] lane_bits(
        input logic [BWM_LANES_MAX-1:0] m_n);
        logic [DW-1:0] r;
        r = '0;
        for (int i = 0; i < LANES; i++) begin
            r[i*LANE_W +: LANE_W] = {LANE_W{~m_n[i]}};
        end
        return r;
    endfunction : lane_bits

    // ------------------------------------------------------------
    // burst sequencing
    // ------------------------------------------------------------
    bwm_state_t state, next_state;
    logic [1:0] beat_idx, next_beat_idx;
    logic [ADDR_W-1:0] base, next_base;
    logic start_ok;

    always_comb begin
        next_state = state;
        next_beat_idx = beat_idx;
        next_base = base;
        // a start right after a start is dropped
        start_ok = !start_n_s2 && (state == BWM_IDLE);
        case (state)
            BWM_IDLE: begin
                if (start_ok) begin
                    next_state = BWM_WAIT;
                    next_base = waddr_s2;
                end
            end
            BWM_WAIT: begin
                next_state = BWM_DATA;
                next_beat_idx = BWM_BEAT_FIRST;
            end
            BWM_DATA: begin
                next_beat_idx = beat_idx + 2'h1;
                if (beat_idx == BWM_BEAT_LAST) begin
                    next_state = BWM_IDLE;
                end
            end
            default: next_state = BWM_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state <= BWM_IDLE;
            beat_idx <= BWM_BEAT_FIRST;
            base <= '0;
        end else begin
            state <= next_state;
            beat_idx <= next_beat_idx;
            base <= next_base;
        end
    end

    // ------------------------------------------------------------
    // masked array write
    // ------------------------------------------------------------
    logic wr_en;
    logic [DW-1:0] bit_en;
    logic [ADDR_W+1:0] wr_word;
    logic [DW-1:0] rd_raw;

    // only beats of a started burst reach the array
    assign wr_en = (state == BWM_DATA) && beat_s2.valid;
    assign bit_en = lane_bits(beat_s2.lane_mask_n);
    assign wr_word = {base, beat_idx};

    bwm_array #(
        .ADDR_W(ADDR_W + BWM_BEAT_W),
        .DATA_W(DW)
    ) u_array (
        .sys_clk_in(sys_clk_in),
        .wr_en_in(wr_en),
        .wr_addr_in(wr_word),
        .wr_data_in(beat_s2.data[DW-1:0]),
        .wr_bit_en_in(bit_en),
        .rd_addr_in(raddr_s2),
        .rd_data_out(rd_raw)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rd_data_out <= '0;
            busy_out <= 1'b0;
            beat_strobe_out <= 1'b0;
        end else begin
            rd_data_out <= BWM_WORD_W'(rd_raw);
            busy_out <= (next_state != BWM_IDLE);
            beat_strobe_out <= wr_en;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_start_beats: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) (state == BWM_IDLE && start_ok) |=>
        (state == BWM_WAIT) ##1 (state == BWM_DATA)[*4] ##1
        (state == BWM_IDLE)) else $error("burst beat timing wrong");
    chk_no_restart: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) (state != BWM_IDLE) |=> (base == $past(base)))
        else $error("start accepted during burst");
    chk_idle_nowrite: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) (state != BWM_DATA) |-> !wr_en)
        else $error("write outside burst");
    chk_all_high: assert property (@(posedge sys_clk_in)
        disable iff (reset_in)
        (beat_s2.lane_mask_n[LANES-1:0] == BWM_MASK_NONE[LANES-1:0])
        |-> (bit_en == '0)) else $error("masked beat wrote bits");
    chk_lane0_low: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) !beat_s2.lane_mask_n[0] |->
        (bit_en[LANE_W-1:0] == '1)) else $error("lane 0 not enabled");
    chk_lane0_high: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) beat_s2.lane_mask_n[0] |->
        (bit_en[LANE_W-1:0] == '0)) else $error("lane 0 enabled");
    chk_top_lane: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) (beat_s2.lane_mask_n[LANES-1] ==
        !bit_en[DW-1])) else $error("top lane enable wrong");
    chk_addr_step: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) (state == BWM_DATA && beat_idx != 2'h3)
        |=> (beat_idx == $past(beat_idx) + 2'h1))
        else $error("beat index skipped");
    chk_strobe_out: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) wr_en |=> beat_strobe_out)
        else $error("beat strobe missing");
    chk_busy_span: assert property (@(posedge sys_clk_in)
        disable iff (reset_in) (state == BWM_IDLE && start_ok) |=>
        busy_out[*5] ##1 !busy_out) else $error("busy span wrong");
endmodule : bwm_top

// ### bwm_ctrl_model.sv
// Purpose: controller model driving write start, address and beats
// Assumes: start is one cycle low, beat pins follow two cycles later
// Notes: released lines invert, so stale values never look valid
module bwm_ctrl_model
    import bwm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic go_in,
    input wire logic dbl_in,
    input wire logic [5:0] addr_in,
    input wire logic [143:0] data_in,
    input wire logic [15:0] mask_in,
    output logic write_port_select_n_out,
    output logic [5:0] wr_addr_out,
    output bwm_beat_t beat_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt;
    int k;
    initial begin
        cnt = 3'h0;
        write_port_select_n_out = 1'b1;
        wr_addr_out = 6'h0;
        beat_out = '0;
    end
    always @(posedge sys_clk_in) begin
        k = int'(cnt) - 2;
        if (cnt == 3'h0) begin
            write_port_select_n_out <= !go_in;
            if (go_in) begin
                wr_addr_out <= addr_in;
                cnt <= 3'h1;
            end
        end else begin
            cnt <= (cnt == 3'h6) ? 3'h0 : cnt + 3'h1;
            // optional second start, which the device must drop
            write_port_select_n_out <= (cnt == 3'h1) ? !dbl_in : 1'b1;
            if (cnt == 3'h6) begin
                wr_addr_out <= ~wr_addr_out;
            end
        end
        if (k >= 0 && k <= 3) begin
            beat_out.valid <= 1'b1;
            beat_out.data <= data_in[36*k +: 36];
            beat_out.lane_mask_n <= mask_in[4*k +: 4];
        end else begin
            beat_out.valid <= 1'b0;
            beat_out.data <= ~beat_out.data;
            beat_out.lane_mask_n <= ~beat_out.lane_mask_n;
        end
    end
endmodule : bwm_ctrl_model

// ### bwm_top_tb_top.sv
// Purpose: self-checking bench for lane masked burst writes, x36 build
// Assumes: controller model in front, shadow words judge the array
// Notes: x8, x9 and x18 builds take the same stream and are checked against the shadows too
module bwm_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import bwm_pkg::*;
    localparam logic [143:0] D1 = 144'h9a5a5a5a5_3c3c3c3c3_0f0f0f0f0_123456789;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic dbl = 1'b0;
    logic [5:0] addr = 6'h0;
    logic [143:0] data = '0;
    logic [15:0] mask = 16'hffff;
    logic [7:0] rd_addr = 8'h0;
    logic write_port_select_n;
    logic [5:0] wr_addr;
    bwm_beat_t beat;
    logic [35:0] rd_data;
    logic [35:0] rd_x8;
    logic [35:0] rd_x9;
    logic [35:0] rd_x18;
    logic busy;
    logic strobe;
    logic [35:0] shadow [256];
    logic [7:0] nib [256];
    int failures = 0;
    int total_checks = 0;
    int strobes = 0;
    int busy_cycles = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (strobe === 1'b1) strobes++;
        if (busy === 1'b1) busy_cycles++;
    end
    bwm_ctrl_model i_ctrl (.sys_clk_in(clk), .go_in(go), .dbl_in(dbl),
        .addr_in(addr), .data_in(data), .mask_in(mask),
        .write_port_select_n_out(write_port_select_n),
        .wr_addr_out(wr_addr), .beat_out(beat));
    bwm_top i_dut (.sys_clk_in(clk), .reset_in(rst),
        .write_port_select_n_in(write_port_select_n), .wr_addr_in(wr_addr),
        .beat_in(beat), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
        .busy_out(busy), .beat_strobe_out(strobe));
    // the same stream feeds the x8, x9 and x18 builds
    bwm_top #(.LANES(2), .LANE_W(4)) i_dut_x8 (.sys_clk_in(clk),
        .reset_in(rst), .write_port_select_n_in(write_port_select_n),
        .wr_addr_in(wr_addr), .beat_in(beat), .rd_addr_in(rd_addr),
        .rd_data_out(rd_x8), .busy_out(), .beat_strobe_out());
    bwm_top #(.LANES(1), .LANE_W(9)) i_dut_x9 (.sys_clk_in(clk),
        .reset_in(rst), .write_port_select_n_in(write_port_select_n),
        .wr_addr_in(wr_addr), .beat_in(beat), .rd_addr_in(rd_addr),
        .rd_data_out(rd_x9), .busy_out(), .beat_strobe_out());
    bwm_top #(.LANES(2), .LANE_W(9)) i_dut_x18 (.sys_clk_in(clk),
        .reset_in(rst), .write_port_select_n_in(write_port_select_n),
        .wr_addr_in(wr_addr), .beat_in(beat), .rd_addr_in(rd_addr),
        .rd_data_out(rd_x18), .busy_out(), .beat_strobe_out());
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [35:0] seen,
                         input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic burst(input logic [5:0] a, input logic [143:0] d,
                         input logic [15:0] m, input logic twice);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        data <= d;
        mask <= m;
        dbl <= twice;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        // shadow keeps only lanes whose mask is low
        // nibble shadow serves the x8 build
        for (int k = 0; k < 4; k++)
            for (int l = 0; l < 4; l++)
                if (!m[4*k+l]) begin
                    shadow[{a, 2'(k)}][9*l +: 9] = d[36*k+9*l +: 9];
                    if (l < 2)
                        nib[{a, 2'(k)}][4*l +: 4] = d[36*k+4*l +: 4];
                end
        repeat (4) @(posedge clk);
        while (busy !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        if (n == 20) begin
            failures++;
            test_done();
        end
    endtask : burst
    task automatic chk_words(input logic [5:0] a);
        logic [35:0] s;
        logic [7:0] n8;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            rd_addr <= {a, 2'(k)};
            // two sync stages ahead of the array add two cycles
            repeat (4) @(posedge clk);
            @(negedge clk);
            s = shadow[{a, 2'(k)}];
            n8 = nib[{a, 2'(k)}];
            check("word", rd_data, s);
            check("word x18", rd_x18, {18'h0, s[17:0]});
            check("word x9", rd_x9, {27'h0, s[8:0]});
            check("word x8", rd_x8, {28'h0, n8});
        end
    endtask : chk_words
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_full_single();
        burst(6'h05, D1, 16'h0000, 1'b0);
        chk_words(6'h05);
        burst(6'h05, ~D1, 16'h7bde, 1'b0);
        chk_words(6'h05);
        $display("test full and single lanes done");
    endtask : t_full_single
    task automatic t_mixed();
        burst(6'h05, {D1[71:0], D1[143:72]}, 16'h05af, 1'b0);
        chk_words(6'h05);
        $display("test mixed lanes done");
    endtask : t_mixed
    task automatic t_double_start();
        strobes = 0;
        busy_cycles = 0;
        burst(6'h09, D1, 16'h0000, 1'b1);
        chk_words(6'h09);
        check("strobes", 36'(strobes), 36'h4);
        check("busy", 36'(busy_cycles), 36'(BWM_BEATS + 1));
        $display("test double start done");
    endtask : t_double_start
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_full_single();
        t_mixed();
        t_double_start();
        test_done();
    end
endmodule : bwm_top_tb_top
